// ===== pkg/fro_pkg.sv
package fro_pkg;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STAT    = 8'h04;
  localparam logic [7:0]  ADDR_OFS1    = 8'h08;
  localparam logic [7:0]  ADDR_OFS2    = 8'h0C;
  localparam int          OFS_HI_LSB   = 16;
  localparam int          CTRL_STALL_C = 0;
  localparam logic [12:0] PRESET_8     = 13'h0008;
  localparam logic [12:0] PRESET_16    = 13'h0010;
  localparam logic [12:0] PRESET_64    = 13'h0040;
  localparam logic [12:0] PRESET_256   = 13'h0100;
  localparam logic [12:0] PRESET_1024  = 13'h0400;
  localparam logic [1:0]  READY_DELAY  = 2'h2;
  localparam logic [2:0]  PAR_WRITES   = 3'h4;
  localparam int          PARITY_BIT   = 8;

  typedef enum logic [1:0] {
    FRO_PRESET,
    FRO_SERIAL,
    FRO_PARALLEL
  } fro_method_t;

  // Preset offset for a flag-select code, zero when the code is no preset
  function automatic logic [12:0] fro_preset(input logic [2:0] fs);
    case (fs)
      3'b111:  fro_preset = PRESET_64;
      3'b110:  fro_preset = PRESET_16;
      3'b101:  fro_preset = PRESET_8;
      3'b011:  fro_preset = PRESET_256;
      3'b001:  fro_preset = PRESET_1024;
      default: fro_preset = 13'h0000;
    endcase
  endfunction : fro_preset

  // Offset from a port A word, optionally skipping the parity bit
  function automatic logic [12:0] fro_extract(input logic [35:0] a, input logic ip, input int w);
    logic [12:0] r;
    r = 13'h0000;
    for (int i = 0; i < 13; i++) begin
      if (i < w) begin
        r[i] = (ip && i >= PARITY_BIT) ? a[i+1] : a[i];
      end
    end
    fro_extract = r;
  endfunction : fro_extract

  // Word of a long word at position idx in transfer order
  function automatic logic [17:0] fro_half(input logic [35:0] l, input logic be, input logic idx);
    fro_half = (be ^ idx) ? l[35:18] : l[17:0];
  endfunction : fro_half
endpackage : fro_pkg

// ===== hw/fro_config_loader.sv
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module fro_config_loader #(
  parameter int OFS_W = 11
) (
  // System
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Configuration pins
  input  wire logic        fifo1_master_reset_n,
  input  wire logic        fifo2_master_reset_n,
  input  wire logic        endian_timing_select,
  input  wire logic        flag_select0_serial_data,
  input  wire logic        flag_select1_serial_enable,
  input  wire logic        flag_select2,
  // Port A write side
  input  wire logic        port_a_write,
  input  wire logic [35:0] port_a_data_bus,
  output logic             fifo1_write,
  output logic [35:0]      fifo1_wdata,
  output logic             port_a_full_n,
  output logic             port_a_input_ready,
  // Port B read side
  input  wire logic        fifo1_long_valid,
  input  wire logic [35:0] fifo1_long_word,
  output logic             fifo1_long_take,
  input  wire logic        port_b_read,
  output logic [17:0]      port_b_data,
  output logic             port_b_empty_n,
  output logic             port_b_output_ready,
  // Port C write side
  input  wire logic        port_c_write,
  input  wire logic [17:0] port_c_data,
  output logic             fifo2_long_valid,
  output logic [35:0]      fifo2_long_word,
  output logic             port_c_full_n,
  output logic             port_c_input_ready,
  // Configuration state
  output logic             byte_order_select,
  output logic             fifo1_fall_through_mode,
  output logic             fifo2_fall_through_mode,
  output logic             interspersed_parity_mode,
  output logic [12:0]      fifo1_empty_offset_reg,
  output logic [12:0]      fifo1_full_offset_reg,
  output logic [12:0]      fifo2_empty_offset_reg,
  output logic [12:0]      fifo2_full_offset_reg
);
  import fro_pkg::*;

  localparam int          SER_BITS = 4 * OFS_W;
  localparam logic [5:0]  SER_LAST = 6'(SER_BITS);

  logic        fifo1_master_reset_n_q;
  logic        fifo2_master_reset_n_q;
  logic        rise1;
  logic        rise2;
  logic        both;
  logic [2:0]  fs;
  logic        tm1_pend_q;
  logic        tm2_pend_q;
  fro_method_t method_q;
  logic [1:0]  rdy1_q;
  logic [1:0]  rdy2_q;
  logic [2:0]  par_cnt_q;
  logic [5:0]  ser_cnt_q;
  logic [51:0] ser_sr_q;
  logic        par_pend;
  logic        ser_pend;
  logic        a_ready;
  logic        c_ready;
  logic        a_take;
  logic        stall_c_q;
  logic [35:0] hold_q;
  logic        hold_v_q;
  logic        idx_q;
  logic        rd_ok;
  logic [17:0] cur_word;
  logic [17:0] b_data_q;
  logic        half_q;
  logic [17:0] first_q;
  logic        ap_wr_q;
  logic [7:0]  ap_addr_q;
  logic        ap_hit;

  assign fs    = {flag_select2, flag_select1_serial_enable, flag_select0_serial_data};
  assign rise1 = fifo1_master_reset_n & ~fifo1_master_reset_n_q;
  assign rise2 = fifo2_master_reset_n & ~fifo2_master_reset_n_q;
  assign both  = rise1 & rise2;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fifo1_master_reset_n_q <= 1'b1;
      fifo2_master_reset_n_q <= 1'b1;
    end else begin
      fifo1_master_reset_n_q <= fifo1_master_reset_n;
      fifo2_master_reset_n_q <= fifo2_master_reset_n;
    end
  end

  // Endian order latched at either release
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      byte_order_select <= 1'b0;
    end else if (rise1 || rise2) begin
      byte_order_select <= endian_timing_select;
    end
  end

  // Timing mode sampled one clock after release
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tm1_pend_q              <= 1'b0;
      tm2_pend_q              <= 1'b0;
      fifo1_fall_through_mode <= 1'b0;
      fifo2_fall_through_mode <= 1'b0;
    end else begin
      tm1_pend_q <= rise1;
      tm2_pend_q <= rise2;
      if (tm1_pend_q && fifo1_master_reset_n) begin
        fifo1_fall_through_mode <= ~endian_timing_select;
      end
      if (tm2_pend_q && fifo2_master_reset_n) begin
        fifo2_fall_through_mode <= ~endian_timing_select;
      end
    end
  end

  // Programming method chosen at the joint release
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      method_q                 <= FRO_PRESET;
      interspersed_parity_mode <= 1'b0;
    end else if (both) begin
      if (fs == 3'b010) begin
        method_q                 <= FRO_SERIAL;
        interspersed_parity_mode <= 1'b0;
      end else if (fs[1:0] == 2'b00) begin
        method_q                 <= FRO_PARALLEL;
        interspersed_parity_mode <= ~flag_select2;
      end else begin
        method_q                 <= FRO_PRESET;
        interspersed_parity_mode <= 1'b0;
      end
    end else if (rise1 || rise2) begin
      method_q                 <= FRO_PRESET;
      interspersed_parity_mode <= 1'b0;
    end
  end

  // Write-side flags rise two clocks after release unless ser_pend, or for port C par_pend or stall_c_q, holds them low
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !fifo1_master_reset_n) begin
      rdy1_q <= 2'h0;
    end else if (rdy1_q != READY_DELAY) begin
      rdy1_q <= rdy1_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !fifo2_master_reset_n) begin
      rdy2_q <= 2'h0;
    end else if (rdy2_q != READY_DELAY) begin
      rdy2_q <= rdy2_q + 2'h1;
    end
  end

  assign par_pend = (method_q == FRO_PARALLEL) && (par_cnt_q != PAR_WRITES);
  assign ser_pend = (method_q == FRO_SERIAL) && (ser_cnt_q != SER_LAST);
  assign a_ready  = (rdy1_q == READY_DELAY) && !ser_pend;
  assign c_ready  = (rdy2_q == READY_DELAY) && !ser_pend && !par_pend && !stall_c_q;
  assign a_take   = port_a_write && a_ready;

  // Flags follow the selected timing mode
  assign port_a_full_n      = a_ready & ~fifo1_fall_through_mode;
  assign port_a_input_ready = a_ready & fifo1_fall_through_mode;
  assign port_c_full_n      = c_ready & ~fifo2_fall_through_mode;
  assign port_c_input_ready = c_ready & fifo2_fall_through_mode;

  // Parallel load counter and FIFO1 write forwarding
  always_ff @(posedge clk_sys) begin
    if (!reset_n || both) begin
      par_cnt_q <= 3'h0;
    end else if (a_take && par_pend) begin
      par_cnt_q <= par_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fifo1_write <= 1'b0;
      fifo1_wdata <= 36'h0_0000_0000;
    end else begin
      fifo1_write <= a_take && !par_pend;
      if (a_take && !par_pend) begin
        fifo1_wdata <= port_a_data_bus;
      end
    end
  end

  // Serial shift of offset bits, most significant of Y1 first
  always_ff @(posedge clk_sys) begin
    if (!reset_n || both) begin
      ser_cnt_q <= 6'h00;
      ser_sr_q  <= 52'h0_0000_0000_0000;
    end else if (ser_pend && !flag_select1_serial_enable && rdy1_q == READY_DELAY) begin
      ser_cnt_q <= ser_cnt_q + 6'h01;
      ser_sr_q  <= {ser_sr_q[50:0], flag_select0_serial_data};
    end
  end

  // Offset registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fifo1_full_offset_reg  <= 13'h0000;
      fifo1_empty_offset_reg <= 13'h0000;
      fifo2_full_offset_reg  <= 13'h0000;
      fifo2_empty_offset_reg <= 13'h0000;
    end else begin
      if (rise1) begin
        fifo1_full_offset_reg  <= fro_preset(fs);
        fifo1_empty_offset_reg <= fro_preset(fs);
      end
      if (rise2) begin
        fifo2_full_offset_reg  <= fro_preset(fs);
        fifo2_empty_offset_reg <= fro_preset(fs);
      end
      if (a_take && par_pend) begin
        case (par_cnt_q)
          3'h0:    fifo1_full_offset_reg  <= fro_extract(port_a_data_bus, interspersed_parity_mode, OFS_W);
          3'h1:    fifo1_empty_offset_reg <= fro_extract(port_a_data_bus, interspersed_parity_mode, OFS_W);
          3'h2:    fifo2_full_offset_reg  <= fro_extract(port_a_data_bus, interspersed_parity_mode, OFS_W);
          default: fifo2_empty_offset_reg <= fro_extract(port_a_data_bus, interspersed_parity_mode, OFS_W);
        endcase
      end
      if (ser_pend && ser_cnt_q == SER_LAST - 6'h01 && !flag_select1_serial_enable
          && rdy1_q == READY_DELAY) begin
        fifo1_full_offset_reg  <= 13'(ser_sr_q[4*OFS_W-2 -: OFS_W]);
        fifo1_empty_offset_reg <= 13'(ser_sr_q[3*OFS_W-2 -: OFS_W]);
        fifo2_full_offset_reg  <= 13'(ser_sr_q[2*OFS_W-2 -: OFS_W]);
        fifo2_empty_offset_reg <= 13'({ser_sr_q[OFS_W-2:0], flag_select0_serial_data});
      end
    end
  end

  // Port B unpacking of long words into two words
  assign cur_word        = fro_half(hold_q, byte_order_select, idx_q);
  assign rd_ok           = port_b_read && hold_v_q;
  assign fifo1_long_take = !hold_v_q && fifo1_long_valid;

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !fifo1_master_reset_n) begin
      hold_q   <= 36'h0_0000_0000;
      hold_v_q <= 1'b0;
      idx_q    <= 1'b0;
    end else if (fifo1_long_take) begin
      hold_q   <= fifo1_long_word;
      hold_v_q <= 1'b1;
      idx_q    <= 1'b0;
    end else if (rd_ok) begin
      idx_q    <= ~idx_q;
      hold_v_q <= ~idx_q;
    end
  end

  // Standard mode shows a word only after its read
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !fifo1_master_reset_n) begin
      b_data_q <= 18'h0_0000;
    end else if (rd_ok) begin
      b_data_q <= cur_word;
    end
  end

  assign port_b_data         = fifo1_fall_through_mode ? cur_word : b_data_q;
  assign port_b_empty_n      = hold_v_q & ~fifo1_fall_through_mode;
  assign port_b_output_ready = hold_v_q & fifo1_fall_through_mode;

  // Port C packing of two words into a long word
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !fifo2_master_reset_n) begin
      half_q           <= 1'b0;
      first_q          <= 18'h0_0000;
      fifo2_long_valid <= 1'b0;
      fifo2_long_word  <= 36'h0_0000_0000;
    end else begin
      fifo2_long_valid <= 1'b0;
      if (port_c_write && c_ready) begin
        half_q <= ~half_q;
        if (!half_q) begin
          first_q <= port_c_data;
        end else begin
          fifo2_long_valid <= 1'b1;
          fifo2_long_word  <= byte_order_select ? {first_q, port_c_data}
                                                : {port_c_data, first_q};
        end
      end
    end
  end

  // AHB-Lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_hit    = hsel && htrans[1] && hready;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_wr_q   <= ap_hit && hwrite;
      ap_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stall_c_q <= 1'b0;
    end else if (ap_wr_q && ap_addr_q == ADDR_CTRL) begin
      stall_c_q <= hwdata[CTRL_STALL_C];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_hit && !hwrite) begin
      case (haddr[7:0])
        ADDR_CTRL: hrdata <= {31'h0000_0000, stall_c_q};
        ADDR_STAT: hrdata <= {21'h00_0000, par_cnt_q, c_ready, a_ready, method_q,
                              interspersed_parity_mode, fifo2_fall_through_mode,
                              fifo1_fall_through_mode, byte_order_select};
        ADDR_OFS1: hrdata <= {3'h0, fifo1_full_offset_reg, 3'h0, fifo1_empty_offset_reg};
        ADDR_OFS2: hrdata <= {3'h0, fifo2_full_offset_reg, 3'h0, fifo2_empty_offset_reg};
        default:   hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : fro_config_loader

// ===== verif/fro_host.sv
`timescale 1ns/10ps
module fro_host (
  // Clock
  input  wire logic clk_sys,
  // Configuration pins
  output logic      fifo1_master_reset_n,
  output logic      fifo2_master_reset_n,
  output logic      endian_timing_select,
  output logic      flag_select0_serial_data,
  output logic      flag_select1_serial_enable,
  output logic      flag_select2
);
  initial begin
    fifo1_master_reset_n = 1'b1;
    fifo2_master_reset_n = 1'b1;
    endian_timing_select = 1'b1;
    {flag_select2, flag_select1_serial_enable, flag_select0_serial_data} = 3'h7;
  end

  // Both resets together, then timing level held until the next reset
  task automatic mreset(input logic [2:0] fs, input logic be, input logic std);
    @(posedge clk_sys);
    fifo1_master_reset_n <= 1'b0;
    fifo2_master_reset_n <= 1'b0;
    endian_timing_select <= be;
    {flag_select2, flag_select1_serial_enable, flag_select0_serial_data} <= fs;
    repeat (5) @(posedge clk_sys);
    fifo1_master_reset_n <= 1'b1;
    fifo2_master_reset_n <= 1'b1;
    @(posedge clk_sys);
    endian_timing_select <= std;
  endtask : mreset

  // Serial offset bits, most significant first, one per clock while enable is low
  task automatic sload(input logic [51:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_sys);
      flag_select1_serial_enable <= 1'b0;
      flag_select0_serial_data   <= bits[i];
    end
    @(posedge clk_sys);
    flag_select1_serial_enable <= 1'b1;
  endtask : sload
endmodule : fro_host

// ===== verif/fro_config_loader_checker.sv
`timescale 1ns/10ps
module fro_config_loader_checker (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        fifo1_master_reset_n,
  input wire logic        fifo2_master_reset_n,
  input wire logic        endian_timing_select,
  input wire logic        flag_select0_serial_data,
  input wire logic        flag_select1_serial_enable,
  input wire logic        flag_select2,
  input wire logic        byte_order_select,
  input wire logic        fifo1_fall_through_mode,
  input wire logic [12:0] fifo1_empty_offset_reg,
  input wire logic [12:0] fifo1_full_offset_reg,
  input wire logic        port_a_write,
  input wire logic [35:0] port_a_data_bus,
  input wire logic        fifo1_write,
  input wire logic [35:0] fifo1_wdata,
  input wire logic        port_a_full_n,
  input wire logic        port_a_input_ready,
  input wire logic [17:0] port_c_data,
  input wire logic        fifo2_long_valid,
  input wire logic [35:0] fifo2_long_word,
  input wire logic        port_c_full_n,
  input wire logic        port_c_input_ready
);
  wire logic [2:0] fs = {flag_select2, flag_select1_serial_enable, flag_select0_serial_data};

  // Preset per flag-select code, zero for non-preset codes
  function automatic logic [12:0] pv(input logic [2:0] c);
    case (c)
      3'b111:  pv = 13'h0040;
      3'b110:  pv = 13'h0010;
      3'b101:  pv = 13'h0008;
      3'b011:  pv = 13'h0100;
      3'b001:  pv = 13'h0400;
      default: pv = 13'h0000;
    endcase
  endfunction : pv

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_bo; $rose(fifo1_master_reset_n) |=> byte_order_select == $past(endian_timing_select); endproperty
  a_bo: assert property (p_bo) else $error("byte order not latched at release");
  property p_mode;
    $rose(fifo1_master_reset_n) ##1 fifo1_master_reset_n |=> fifo1_fall_through_mode == !$past(endian_timing_select);
  endproperty
  a_mode: assert property (p_mode) else $error("timing mode not latched");
  property p_preset; ($rose(fifo1_master_reset_n) && pv(fs) != 13'h0000) |=>
    fifo1_empty_offset_reg == pv($past(fs)) && fifo1_full_offset_reg == pv($past(fs)); endproperty
  a_preset: assert property (p_preset) else $error("preset offsets wrong");
  property p_low_a; !fifo1_master_reset_n |=> !port_a_full_n && !port_a_input_ready; endproperty
  a_low_a: assert property (p_low_a) else $error("port A ready during reset");
  property p_low_c; !fifo2_master_reset_n |=> !port_c_full_n && !port_c_input_ready; endproperty
  a_low_c: assert property (p_low_c) else $error("port C ready during reset");
  property p_rise; ($rose(fifo1_master_reset_n) && pv(fs) != 13'h0000) ##1 fifo1_master_reset_n [*2]
    |=> port_a_full_n || port_a_input_ready; endproperty
  a_rise: assert property (p_rise) else $error("port A ready late");
  property p_fw; fifo1_write |-> $past(port_a_write) && fifo1_wdata == $past(port_a_data_bus); endproperty
  a_fw: assert property (p_fw) else $error("forwarded word without its write");
  property p_pack; fifo2_long_valid |->
    (byte_order_select ? fifo2_long_word[17:0] : fifo2_long_word[35:18]) == $past(port_c_data); endproperty
  a_pack: assert property (p_pack) else $error("last port C word misplaced");
  property p_stable; fifo1_master_reset_n && $past(fifo1_master_reset_n) && flag_select1_serial_enable &&
    !port_a_write |=> $stable(fifo1_empty_offset_reg) && $stable(fifo1_full_offset_reg); endproperty
  a_stable: assert property (p_stable) else $error("offset changed without a load");
  c_rel: cover property ($rose(fifo1_master_reset_n));
  c_fw: cover property (fifo1_write);
  c_pack: cover property (fifo2_long_valid);
endmodule : fro_config_loader_checker

bind fro_config_loader fro_config_loader_checker u_fro_config_loader_checker (
  .clk_sys, .reset_n, .fifo1_master_reset_n, .fifo2_master_reset_n, .endian_timing_select,
  .flag_select0_serial_data, .flag_select1_serial_enable, .flag_select2, .byte_order_select,
  .fifo1_fall_through_mode, .fifo1_empty_offset_reg, .fifo1_full_offset_reg, .port_a_write, .port_a_data_bus,
  .fifo1_write, .fifo1_wdata, .port_a_full_n, .port_a_input_ready, .port_c_data, .fifo2_long_valid,
  .fifo2_long_word, .port_c_full_n, .port_c_input_ready);

// ===== verif/fro_config_loader_tb.sv
`timescale 1ns/10ps
module fro_config_loader_tb;
  import fro_pkg::*;
  logic        clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        port_a_write = 1'b0, fifo1_long_valid = 1'b0, port_b_read = 1'b0, port_c_write = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [35:0] port_a_data_bus = 36'h0, fifo1_long_word = 36'h0, fifo1_wdata, fifo2_long_word;
  logic [17:0] port_c_data = 18'h0, port_b_data;
  logic [12:0] fifo1_empty_offset_reg, fifo1_full_offset_reg, fifo2_empty_offset_reg, fifo2_full_offset_reg;
  logic        hreadyout, hresp, fifo1_write, port_a_full_n, port_a_input_ready, fifo1_long_take;
  logic        port_b_empty_n, port_b_output_ready, fifo2_long_valid, port_c_full_n, port_c_input_ready;
  logic        byte_order_select, fifo1_fall_through_mode, fifo2_fall_through_mode, interspersed_parity_mode;
  logic        fifo1_master_reset_n, fifo2_master_reset_n, endian_timing_select;
  logic        flag_select0_serial_data, flag_select1_serial_enable, flag_select2;
  int          n_mismatch = 0, checks = 0, n_fw = 0;
  wire logic   a_rdy = port_a_full_n | port_a_input_ready;
  wire logic   c_rdy = port_c_full_n | port_c_input_ready;

  fro_config_loader #(.OFS_W(11)) u_fro_config_loader (
    .clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .fifo1_master_reset_n, .fifo2_master_reset_n, .endian_timing_select,
    .flag_select0_serial_data, .flag_select1_serial_enable, .flag_select2, .port_a_write,
    .port_a_data_bus, .fifo1_write, .fifo1_wdata, .port_a_full_n, .port_a_input_ready, .fifo1_long_valid,
    .fifo1_long_word, .fifo1_long_take, .port_b_read, .port_b_data, .port_b_empty_n, .port_b_output_ready,
    .port_c_write, .port_c_data, .fifo2_long_valid, .fifo2_long_word, .port_c_full_n, .port_c_input_ready,
    .byte_order_select, .fifo1_fall_through_mode, .fifo2_fall_through_mode, .interspersed_parity_mode,
    .fifo1_empty_offset_reg, .fifo1_full_offset_reg, .fifo2_empty_offset_reg, .fifo2_full_offset_reg);
  fro_host u_fro_host (.clk_sys, .fifo1_master_reset_n, .fifo2_master_reset_n, .endian_timing_select,
    .flag_select0_serial_data, .flag_select1_serial_enable, .flag_select2);

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (fifo1_write === 1'b1) n_fw++;

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic pa_write(input logic [35:0] d);
    do @(negedge clk_sys); while (a_rdy !== 1'b1);
    @(posedge clk_sys);
    port_a_write <= 1'b1;
    port_a_data_bus <= d;
    @(posedge clk_sys);
    port_a_write <= 1'b0;
    port_a_data_bus <= ~d;
  endtask : pa_write

  task automatic t_preset();
    logic [31:0] rd;
    logic [2:0]  fs [5];
    logic [12:0] pv [5];
    fs = '{3'b111, 3'b110, 3'b101, 3'b011, 3'b001};
    pv = '{PRESET_64, PRESET_16, PRESET_8, PRESET_256, PRESET_1024};
    for (int i = 0; i < 5; i++) begin
      u_fro_host.mreset(fs[i], i[0], 1'b1);
      ahb(1'b0, ADDR_OFS1, 32'h0, rd);
      check(rd, {3'h0, pv[i], 3'h0, pv[i]});
      ahb(1'b0, ADDR_OFS2, 32'h0, rd);
      check(rd, {3'h0, pv[i], 3'h0, pv[i]});
    end
  endtask : t_preset

  task automatic t_serial();
    logic [31:0] rd;
    u_fro_host.mreset(3'b010, 1'b0, 1'b1);
    repeat (3) @(posedge clk_sys);
    ahb(1'b0, ADDR_STAT, 32'h0, rd);
    check(rd[7:4], 4'b0001);
    u_fro_host.sload({8'h00, 11'h123, 11'h045, 11'h7FC, 11'h001}, 44);
    ahb(1'b0, ADDR_STAT, 32'h0, rd);
    check(rd[7:6], 2'b11);
    ahb(1'b0, ADDR_OFS1, 32'h0, rd);
    check(rd, {3'h0, 13'h0123, 3'h0, 13'h0045});
    ahb(1'b0, ADDR_OFS2, 32'h0, rd);
    check(rd, {3'h0, 13'h07FC, 3'h0, 13'h0001});
  endtask : t_serial

  task automatic t_par(input logic ip);
    logic [31:0] rd;
    logic [12:0] v [4];
    int          n0;
    v = '{13'h0001, 13'h07FC, 13'h0555, 13'h02AA};
    u_fro_host.mreset({~ip, 2'b00}, 1'b0, 1'b1);
    n0 = n_fw;
    // Junk above the offset field, parity bit set when ip
    for (int i = 0; i < 4; i++) begin
      pa_write(ip ? {24'hFFFFFF, v[i][10:8], 1'b1, v[i][7:0]} : {25'h1FFFFFF, v[i][10:0]});
    end
    do @(negedge clk_sys); while (c_rdy !== 1'b1);
    check(36'(n_fw - n0), 36'h0);
    ahb(1'b0, ADDR_STAT, 32'h0, rd);
    check(rd[7:0], {4'b1110, ip, 3'b000});
    ahb(1'b0, ADDR_OFS1, 32'h0, rd);
    check(rd, {3'h0, v[0], 3'h0, v[1]});
    ahb(1'b0, ADDR_OFS2, 32'h0, rd);
    check(rd, {3'h0, v[2], 3'h0, v[3]});
    check({interspersed_parity_mode, fifo2_full_offset_reg, fifo2_empty_offset_reg}, {ip, v[2], v[3]});
    pa_write(36'h123456789);
    @(negedge clk_sys);
    check(fifo1_wdata, 36'h123456789);
    @(negedge clk_sys);
    check(36'(n_fw - n0), 36'h1);
  endtask : t_par

  task automatic t_order(input logic be, input logic fw);
    logic [31:0] rd;
    logic [35:0] lw;
    logic [17:0] cw [2];
    lw = 36'h9ABCD1234;
    cw = '{18'h2A5A5, 18'h15A5A};
    u_fro_host.mreset(3'b111, be, ~fw);
    repeat (3) @(posedge clk_sys);
    ahb(1'b0, ADDR_STAT, 32'h0, rd);
    check(rd[7:0], {5'b11000, fw, fw, be});
    check({port_a_full_n, port_a_input_ready, port_c_full_n, port_c_input_ready}, {!fw, fw, !fw, fw});
    check({byte_order_select, fifo2_fall_through_mode, interspersed_parity_mode}, {be, fw, 1'b0});
    fifo1_long_word <= lw;
    fifo1_long_valid <= 1'b1;
    do @(negedge clk_sys); while (fifo1_long_take !== 1'b1);
    @(posedge clk_sys);
    fifo1_long_valid <= 1'b0;
    fifo1_long_word <= ~lw;
    // Fall-through shows the first word unread
    for (int i = 0; i < 2; i++) begin
      if (!fw || i == 1) port_b_read <= 1'b1;
      @(posedge clk_sys);
      port_b_read <= 1'b0;
      @(negedge clk_sys);
      check({port_b_empty_n, port_b_output_ready}, fw ? 2'b01 : {!i[0], 1'b0});
      check(port_b_data, (be ^ i[0]) ? lw[35:18] : lw[17:0]);
      @(posedge clk_sys);
    end
    for (int i = 0; i < 2; i++) begin
      do @(negedge clk_sys); while (c_rdy !== 1'b1);
      @(posedge clk_sys);
      port_c_write <= 1'b1;
      port_c_data <= cw[i];
      @(posedge clk_sys);
      port_c_write <= 1'b0;
      port_c_data <= ~cw[i];
    end
    do @(negedge clk_sys); while (fifo2_long_valid !== 1'b1);
    check(fifo2_long_word, be ? {cw[0], cw[1]} : {cw[1], cw[0]});
  endtask : t_order

  task automatic t_regs();
    logic [31:0] rd;
    ahb(1'b1, ADDR_CTRL, 32'h1, rd);
    ahb(1'b0, ADDR_CTRL, 32'h0, rd);
    check(rd, 32'h1);
    check(c_rdy, 1'b0);
    ahb(1'b1, ADDR_CTRL, 32'h0, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    check(hresp, 1'b0);
  endtask : t_regs

  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_preset();
    t_serial();
    t_par(1'b0);
    t_par(1'b1);
    for (int k = 0; k < 4; k++) t_order(k[0], k[1]);
    t_regs();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end
endmodule : fro_config_loader_tb
